// ---- bench/cdt_top_bench.sv ----
/* cdt_top_bench: scenario tasks for cdt_top.
   assumes: DTS_DIV of 1, so one dead-time period is one cycle. */
`timescale 1ns/10ps
`define CHK(a,b,m) begin checked++; if ((a) !== (b)) begin num_errors++; $display("mismatch %0t %s", $time, m); end end
module cdt_top_bench
   import cdt_pkg::*;
;
   logic        ref_clk, nrst, reg_wr, reg_rd, primary_output_enable, shoot;
   logic        shared_run_off_state_sel, shared_idle_off_state_sel;
   logic        chan0_out_en, chan0_comp_out_en, chan1_out_en, chan1_comp_out_en;
   logic        chan0_out, chan0_comp_out, chan1_out, chan1_comp_out;
   logic [7:0]  reg_addr, shared_dead_time_cfg;
   logic [31:0] reg_wdata, reg_rdata_q;
   logic [1:0]  protect_level, chan_ref;
   int          num_errors, checked;
   // design and far-side switches
   cdt_top #(.DTS_DIV(1)) u_cdt_top (.*);
   power_switch_model u_power_switch_model (.hi(chan1_out), .lo(chan1_comp_out), .shoot_q(shoot));
   // 250 MHz kernel clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
      @(posedge ref_clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      @(posedge ref_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
      @(posedge ref_clk) reg_rd <= 1'b0;
      #1 `CHK(reg_rdata_q, x, "read data")
   endtask
   task automatic t_regs;
      rd(CHAN0_CFG_OFS, CFG_RESET);
      rd(CHAN1_CFG_OFS, CFG_RESET);
      wr(CHAN1_CFG_OFS, 32'h8000_0cff);
      rd(CHAN1_CFG_OFS, 32'h8000_0cff);
      @(posedge ref_clk) protect_level <= 2'h1;
      wr(CHAN1_CFG_OFS, 32'h0);
      rd(CHAN1_CFG_OFS, 32'h8000_00ff);
      for (int p = 2; p < 4; p++) begin
         @(posedge ref_clk) protect_level <= p[1:0];
         wr(CHAN1_CFG_OFS, 32'h0000_0c00);
         rd(CHAN1_CFG_OFS, 32'h8000_00ff);
      end
      @(posedge ref_clk) protect_level <= 2'h1;
      wr(CHAN1_CFG_OFS, 32'h0000_0c00);
      rd(CHAN1_CFG_OFS, 32'h8000_0cff);
      rd(8'h84, 32'h8000_0cff);
      rd(CHAN0_CFG_OFS, CFG_RESET);
      @(posedge ref_clk) protect_level <= PROTECT_LEVEL_OPEN;
   endtask
   task automatic gate_step(input logic [3:0] v, input logic x);
      @(posedge ref_clk) {primary_output_enable, shared_run_off_state_sel,
         shared_idle_off_state_sel, chan0_out_en} <= v;
      repeat (8) @(posedge ref_clk);
      #1 `CHK(chan0_out, x, "gated output")
   endtask
   task automatic t_gate;
      @(posedge ref_clk) begin chan_ref <= 2'b01; chan0_comp_out_en <= 1'b1; end
      gate_step(4'b1001, 1'b0);
      gate_step(4'b1101, 1'b1);
      gate_step(4'b0101, 1'b0);
      gate_step(4'b0011, 1'b1);
      gate_step(4'b0010, 1'b0);
      // reference low hands the pair to the complementary side
      @(posedge ref_clk) begin
         chan_ref[0] <= 1'b0;
         {primary_output_enable, shared_run_off_state_sel} <= 2'b11;
      end
      repeat (8) @(posedge ref_clk);
      #1 `CHK(chan0_comp_out, 1'b1, "complement output")
   endtask
   task automatic dt_meas(input int l);
      int n;
      @(posedge ref_clk) chan_ref[1] <= 1'b0;
      repeat (l + 8) @(posedge ref_clk);
      #1 `CHK(chan1_comp_out, 1'b1, "complement before edge")
      @(posedge ref_clk) chan_ref[1] <= 1'b1;
      n = 0;
      while (chan1_out !== 1'b1 && n < 1200) begin @(posedge ref_clk); #1 n++; end
      `CHK(n >= l + 1 && n <= l + 4, 1'b1, "dead time")
      `CHK(shoot, 1'b0, "shoot-through")
   endtask
   task automatic t_dead;
      logic [7:0] c[4] = '{8'h05, 8'ha3, 8'hc2, 8'he1};
      int         len[4] = '{5, 198, 272, 528};
      @(posedge ref_clk) begin {chan1_out_en, chan1_comp_out_en, primary_output_enable} <= 3'b111; end
      for (int i = 0; i < 4; i++) begin
         wr(CHAN1_CFG_OFS, {24'h8000_0c, c[i]});
         dt_meas(len[i]);
      end
      @(posedge ref_clk) begin shared_dead_time_cfg <= 8'h10; shared_run_off_state_sel <= 1'b1; end
      wr(CHAN1_CFG_OFS, 32'h0000_0c00);
      dt_meas(16);
   endtask
   task automatic close_out;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // reset, then the scenarios
   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata, protect_level, chan_ref, shared_dead_time_cfg} = '0;
      {primary_output_enable, shared_run_off_state_sel, shared_idle_off_state_sel} = '0;
      {chan0_out_en, chan0_comp_out_en, chan1_out_en, chan1_comp_out_en, nrst} = '0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      t_regs;
      t_gate;
      t_dead;
      close_out;
   end
   // watchdog against a hang
   initial begin
      #100000;
      num_errors++;
      close_out;
   end
endmodule // cdt_top_bench

// ---- bench/cdt_top_props.sv ----
/* cdt_top_props: port assertions for cdt_top.
   assumes: bound into every cdt_top, one kernel clock. */
`timescale 1ns/10ps
module cdt_top_props
   import cdt_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        nrst,
   // register read port
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_rdata_q,
   // channel controls
   input wire logic        chan0_out_en,
   input wire logic [1:0]  chan_ref,
   // pairs
   input wire logic        chan0_out,
   input wire logic        chan0_comp_out,
   input wire logic        chan1_out,
   input wire logic        chan1_comp_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // a pair with both outputs off
   sequence s_off0; !chan0_out && !chan0_comp_out; endsequence
   sequence s_off1; !chan1_out && !chan1_comp_out; endsequence
   // address of a mapped register
   wire logic hit = (reg_addr == CHAN0_CFG_OFS) || (reg_addr == CHAN1_CFG_OFS);
   a_pair0_excl: assert property (!(chan0_out && chan0_comp_out)) else $error("pair 0 overlap");
   a_pair1_excl: assert property (!(chan1_out && chan1_comp_out)) else $error("pair 1 overlap");
   a_ref0_blank: assert property ($changed(chan_ref[0]) |=> s_off0) else $error("pair 0 not blanked");
   a_ref1_blank: assert property ($changed(chan_ref[1]) |=> s_off1) else $error("pair 1 not blanked");
   a_rise_ref: assert property ($rose(chan1_out) |-> $past(chan_ref[1])) else $error("wrong side rose");
   a_out_enable: assert property (chan0_out |-> $past(chan0_out_en)) else $error("out without enable");
   a_rsvd_zero: assert property (reg_rd && hit |=> (reg_rdata_q & 32'h7fff_f300) == 32'h0)
      else $error("reserved bits set");
   a_miss_hold: assert property (reg_rd && !hit |=> $stable(reg_rdata_q)) else $error("miss changed data");
   a_idle_hold: assert property (!reg_rd |=> $stable(reg_rdata_q)) else $error("data moved");
endmodule // cdt_top_props
bind cdt_top cdt_top_props u_cdt_top_props (.*);

// ---- bench/power_switch_model.sv ----
/* power_switch_model: high and low side switches of one pair.
   assumes: gate drives are active high. */
`timescale 1ns/10ps
module power_switch_model (
   // gate drives
   input wire logic hi,
   input wire logic lo,
   // latched shoot-through flag
   output logic     shoot_q
);
   // both switches on at once shorts the rail
   initial shoot_q = 1'b0;
   always @(hi or lo) if (hi && lo) shoot_q = 1'b1;
endmodule // power_switch_model

// ---- hdl/cdt_if.sv ----
/*
 interface: carries one channel's effective settings from the register file to its dead-time pair.
 assumes: both ends clocked by ref_clk.
*/
`timescale 1ns/10ps
interface cdt_if;
   logic       run_off_state_sel;
   logic       idle_off_state_sel;
   logic [7:0] dead_time_cfg;
   modport src (output run_off_state_sel, output idle_off_state_sel, output dead_time_cfg);
   modport dst (input  run_off_state_sel, input  idle_off_state_sel, input  dead_time_cfg);
endinterface // cdt_if

// ---- hdl/cdt_pkg.sv ----
/*
 package: register offsets, field positions, reset values and dead-time timing constants for the
 complementary output override block.
 assumes: one 250 MHz kernel clock; word-only register access.
*/
package cdt_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0]  CHAN0_CFG_OFS     = 8'h7c;
   localparam logic [7:0]  CHAN1_CFG_OFS     = 8'h80;
   // field positions
   localparam int          SEL_BIT           = 31;
   localparam int          RUN_OFF_BIT       = 11;
   localparam int          IDLE_OFF_BIT      = 10;
   localparam int          DT_MSB            = 7;
   // reset value
   localparam logic [31:0] CFG_RESET         = 32'h0000_0000;
   // protection levels
   localparam logic [1:0]  PROTECT_LEVEL_OPEN         = 2'h0;
   // dead-time decode constants
   localparam logic [10:0] DT_BASE_64        = 11'h040;
   localparam logic [10:0] DT_BASE_32        = 11'h020;
   // kernel clock period in ns and dead-time clock division
   localparam int          CLK_PERIOD_NS     = 4;
   localparam int          DTS_DIV_DEFAULT   = 1;
   // widest dead-time count: (32+31)*16 periods
   localparam int          DT_CNT_W          = 11;
endpackage

// ---- hdl/cdt_top.sv ----
/*
 cdt_top: per-channel complementary output override registers for channels 0 and 1, with
 protection locking, shared/private selection and dead-time pairs.
 assumes: word-only register writes from the timer register file; protect_level and the shared
 register fields come from the timer's shared protection register.
*/
// How it works
// - with the primary output enable clear, idle off-state 0 disables the pair, 1 follows the channel enables.
// - with the primary output enable set, run off-state 0 disables the pair, 1 follows the channel enables.
// - writes to run and idle off-state bits are ignored at protection level 10 or 11.
// - writes to the dead-time field and select bit are taken only at protection level 00.
// - the programmed dead-time is inserted after each reference edge before either output of the pair turns on; turn-off is not delayed.
// - top dead-time bit 0 gives the 8-bit value times one dead-time clock period.
// - top bits 10x give 64 plus the low six bits, times two periods.
// - top bits 110 give 32 plus the low five bits, times eight periods.
// - top bits 111 give 32 plus the low five bits, times sixteen periods.
// - the select bit at 31 picks the shared fields at 0 and this register's fields at 1.
// - each register governs only its own channel pair.
`timescale 1ns/10ps
module cdt_top
   import cdt_pkg::*;
#(
   parameter int DTS_DIV = DTS_DIV_DEFAULT
)(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // register write/read port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic [31:0]      reg_rdata_q,
   // shared protection register fields
   input  wire logic [1:0]  protect_level,
   input  wire logic        shared_run_off_state_sel,
   input  wire logic        shared_idle_off_state_sel,
   input  wire logic [7:0]  shared_dead_time_cfg,
   input  wire logic        primary_output_enable,
   // channel enables and references
   input  wire logic        chan0_out_en,
   input  wire logic        chan0_comp_out_en,
   input  wire logic        chan1_out_en,
   input  wire logic        chan1_comp_out_en,
   input  wire logic [1:0]  chan_ref,
   // complementary pairs
   output logic             chan0_out,
   output logic             chan0_comp_out,
   output logic             chan1_out,
   output logic             chan1_comp_out
);
   logic [31:0] cfg_q [2];
   logic [31:0] cfg_d [2];
   logic [31:0] rdata_d;
   logic [15:0] div_q, div_d;
   logic        dts_en;
   logic [1:0]  pout, pcomp;
   logic [1:0]  en_o, en_c;

   cdt_if eff [2] ();

   // dead-time clock enable divider
   always_comb begin
      dts_en = (div_q == 16'(DTS_DIV - 1));
      div_d  = dts_en ? 16'h0000 : div_q + 16'h0001;
   end

   // register writes with protection-level locking; only the addressed register changes
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cfg_d[i] = cfg_q[i];
         if (reg_wr && reg_addr == (i == 0 ? CHAN0_CFG_OFS : CHAN1_CFG_OFS)) begin
            if (!protect_level[1]) begin
               cfg_d[i][RUN_OFF_BIT]  = reg_wdata[RUN_OFF_BIT];
               cfg_d[i][IDLE_OFF_BIT] = reg_wdata[IDLE_OFF_BIT];
            end
            if (protect_level == PROTECT_LEVEL_OPEN) begin
               cfg_d[i][SEL_BIT]      = reg_wdata[SEL_BIT];
               cfg_d[i][DT_MSB:0]     = reg_wdata[DT_MSB:0];
            end
         end
      end
      // reads: reserved bits always zero, unmapped address keeps the last read data
      if (reg_rd && reg_addr == CHAN0_CFG_OFS)
         rdata_d = cfg_q[0];
      else if (reg_rd && reg_addr == CHAN1_CFG_OFS)
         rdata_d = cfg_q[1];
      else
         rdata_d = reg_rdata_q;
   end

   // register state
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q[0]    <= CFG_RESET;
         cfg_q[1]    <= CFG_RESET;
         div_q       <= 16'h0000;
         reg_rdata_q <= CFG_RESET;
      end else begin
         cfg_q[0]    <= cfg_d[0];
         cfg_q[1]    <= cfg_d[1];
         div_q       <= div_d;
         reg_rdata_q <= rdata_d;
      end
   end

   assign en_o = {chan1_out_en, chan0_out_en};
   assign en_c = {chan1_comp_out_en, chan0_comp_out_en};

   // per-channel select and dead-time pair
   for (genvar g = 0; g < 2; g++) begin : g_chan
      assign eff[g].run_off_state_sel  = cfg_q[g][SEL_BIT] ? cfg_q[g][RUN_OFF_BIT]
                                                           : shared_run_off_state_sel;
      assign eff[g].idle_off_state_sel = cfg_q[g][SEL_BIT] ? cfg_q[g][IDLE_OFF_BIT]
                                                           : shared_idle_off_state_sel;
      assign eff[g].dead_time_cfg      = cfg_q[g][SEL_BIT] ? cfg_q[g][DT_MSB:0]
                                                           : shared_dead_time_cfg;
      dt_pair u_pair (
         .ref_clk               (ref_clk),
         .nrst                  (nrst),
         .dts_en                (dts_en),
         .cfg                   (eff[g]),
         .primary_output_enable (primary_output_enable),
         .out_en                (en_o[g]),
         .comp_out_en           (en_c[g]),
         .ref_level             (chan_ref[g]),
         .out_q                 (pout[g]),
         .comp_q                (pcomp[g])
      );
   end

   // pair outputs are flops inside dt_pair
   assign chan0_out      = pout[0];
   assign chan0_comp_out = pcomp[0];
   assign chan1_out      = pout[1];
   assign chan1_comp_out = pcomp[1];
endmodule // cdt_top

// ---- hdl/dt_pair.sv ----
/*
 dt_pair: one complementary output pair with dead-time insertion and off-state gating.
 assumes: dts_en is a one-cycle pulse at the dead-time clock rate.
*/
`timescale 1ns/10ps
module dt_pair
   import cdt_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic nrst,
   // timebase
   input  wire logic dts_en,
   // effective settings
   cdt_if.dst        cfg,
   // timer control
   input  wire logic primary_output_enable,
   input  wire logic out_en,
   input  wire logic comp_out_en,
   input  wire logic ref_level,
   // pair outputs
   output logic      out_q,
   output logic      comp_q
);
   logic [DT_CNT_W-1:0] cnt_q, cnt_d, dt_len;
   logic                ref_q, ref_d, out_d, comp_d, gate;
   logic [7:0]          dt;

   // decode dead-time field into dead-time clock periods
   always_comb begin
      dt = cfg.dead_time_cfg;
      if (!dt[DT_MSB])
         dt_len = {3'h0, dt};
      else if (dt[7:6] == 2'h2)
         dt_len = 11'((DT_BASE_64 + {5'h0, dt[5:0]}) << 1);
      else if (dt[7:5] == 3'h6)
         dt_len = 11'((DT_BASE_32 + {6'h0, dt[4:0]}) << 3);
      else
         dt_len = 11'((DT_BASE_32 + {6'h0, dt[4:0]}) << 4);
   end

   // reference edge restarts count; outputs rise only after count expires
   always_comb begin
      ref_d = ref_level;
      cnt_d = cnt_q;
      if (ref_level != ref_q)
         cnt_d = dt_len;
      else if (dts_en && cnt_q != '0)
         cnt_d = cnt_q - 11'h001;
      // off-state gating
      if (primary_output_enable)
         gate = cfg.run_off_state_sel;
      else
         gate = cfg.idle_off_state_sel;
      out_d  = gate & out_en & ref_q & (ref_level == ref_q) & (cnt_q == '0);
      comp_d = gate & comp_out_en & ~ref_q & (ref_level == ref_q) & (cnt_q == '0);
   end

   // state registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q  <= '0;
         ref_q  <= 1'b0;
         out_q  <= 1'b0;
         comp_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         ref_q  <= ref_d;
         out_q  <= out_d;
         comp_q <= comp_d;
      end
   end
endmodule // dt_pair
